/* File: pmc_power_mode_controller.sv */
// global power mode controller: templates, mode entry, wakeup, resume
`timescale 1ns/1ps

module pmc_power_mode_controller
	import pmc_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              clkEn,
	// register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdData,
	// wakeup and reset event inputs (asynchronous)
	input  wire logic              periphIrq,
	input  wire logic              supervisorIrq,
	input  wire logic              pinInterruptUnitIrq,
	input  wire logic              comparatorIrq,
	input  wire logic              i2cIrq,
	input  wire logic              rtcIrq,
	input  wire logic              lowVoltageDetectIrq,
	input  wire logic              externalResetPinN,
	input  wire logic              watchdogResetEvent,
	input  wire logic              preciseSupplyReset,
	// subsystem controls
	output logic [NUM_SUBSYS-1:0]  subsysClkEn,
	output logic [NUM_SUBSYS-1:0]  subsysBiasEn,
	// regulators and oscillators
	output logic                   digRegEn,
	output logic                   anaRegEn,
	output logic                   hibRegEn,
	output logic                   fastOscEn,
	output logic                   lowSpeedInternalOscEn,
	output logic                   watchCrystalOscEn,
	// pin retention
	output logic                   pinHold,
	output logic                   pinIrqCfgHold,
	// mode status
	output logic [2:0]             globalMode,
	output logic                   wakeEvent
);

	// ----------------------------------------
	// reset release and input synchronisers
	// ----------------------------------------
	logic [1:0] rstSync_ff;
	logic       rstSyncN;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_ff <= 2'h0;
		end else begin
			rstSync_ff <= {rstSync_ff[0], 1'b1};
		end
	end
	assign rstSyncN = rstSync_ff[1];

	localparam int NUM_IN = 11;
	logic [NUM_IN-1:0] rawIn;
	logic [NUM_IN-1:0] syncA_ff;
	logic [NUM_IN-1:0] syncB_ff;

	// low byte follows the wake enable layout; slot 2 is the timewheel,
	// filled in after the syncs; resets sit above the enable byte
	assign rawIn = {preciseSupplyReset, watchdogResetEvent,
		~externalResetPinN, lowVoltageDetectIrq, rtcIrq, i2cIrq,
		comparatorIrq, pinInterruptUnitIrq, 1'b0, supervisorIrq,
		periphIrq};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rstSyncN) begin
				if (!rstSyncN) begin
					syncA_ff[gi] <= 1'b0;
					syncB_ff[gi] <= 1'b0;
				end else if (clkEn) begin
					syncA_ff[gi] <= rawIn[gi];
					syncB_ff[gi] <= syncA_ff[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [DATA_W-1:0] actTmpl_ff;
	logic [DATA_W-1:0] altTmpl_ff;
	logic [DATA_W-1:0] wakeEn_ff;
	logic              reqValid_ff;
	logic [1:0]        reqMode_ff;
	logic              twClr_ff;
	pmc_state_t        state_ff;
	logic              cpuForce_ff;

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			actTmpl_ff <= ACT_TMPL_RST;
			altTmpl_ff <= ALT_TMPL_RST;
			wakeEn_ff <= WAKE_EN_RST;
			twClr_ff <= 1'b0;
		end else if (clkEn) begin
			twClr_ff <= regWr && (regAddr == ADDR_TW_CTRL) && regWrData[0];
			if (regWr && regAddr == ADDR_ACT_TMPL) begin
				actTmpl_ff <= regWrData;
			end
			if (regWr && regAddr == ADDR_ALT_TMPL) begin
				altTmpl_ff <= regWrData;
			end
			if (regWr && regAddr == ADDR_WAKE_EN) begin
				wakeEn_ff <= regWrData;
			end
		end
	end

	// pending request: only a write here may start a low power mode
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			reqValid_ff <= 1'b0;
			reqMode_ff <= 2'h0;
		end else if (clkEn) begin
			if (regWr && regAddr == ADDR_MODE_REQ &&
				regWrData[1:0] != 2'h0) begin
				reqValid_ff <= 1'b1;
				reqMode_ff <= regWrData[1:0];
			end else begin
				reqValid_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// timewheel
	// ----------------------------------------
	pmc_tw_if tw ();

	assign tw.run = (state_ff != PMC_HIB);
	assign tw.clear = twClr_ff;

	pmc_timewheel u_wheel (
		.clk      (clk),
		.rstSyncN (rstSyncN),
		.clkEn    (clkEn),
		.tw       (tw)
	);

	// ----------------------------------------
	// wakeup decode
	// ----------------------------------------
	logic [NUM_WAKE-1:0] irqVec;
	logic                resetWake;
	logic                irqWake;
	logic                sleepWake;
	logic                anyWake;

	always_comb begin
		irqVec = syncB_ff[NUM_WAKE-1:0];
		irqVec[WK_TWHEEL] = tw.wrap;
	end
	assign resetWake = |syncB_ff[NUM_IN-1:NUM_WAKE];
	assign irqWake = |(irqVec & wakeEn_ff);
	// sleep keeps only the listed sources alive
	assign sleepWake = |(irqVec & wakeEn_ff & {1'b1, 1'b1, 1'b1, 1'b1,
		1'b1, 1'b0, 1'b0, 1'b0}) | (irqVec[WK_TWHEEL] & wakeEn_ff[WK_TWHEEL])
		| resetWake;
	assign anyWake = irqWake | resetWake;

	// ----------------------------------------
	// mode state machine
	// ----------------------------------------
	pmc_state_t       nxt_state;
	logic [CNT_W-1:0] resumeCnt_ff;
	logic [CNT_W-1:0] resumeLen_ff;
	logic             wake;

	always_comb begin
		nxt_state = state_ff;
		wake = 1'b0;
		unique case (state_ff)
			PMC_ACTIVE, PMC_ALT: begin
				if (anyWake) begin
					wake = 1'b1;
					nxt_state = PMC_ACTIVE;
				end else if (reqValid_ff) begin
					unique case (reqMode_ff)
						REQ_ALT: nxt_state = PMC_ALT;
						REQ_SLEEP: nxt_state = PMC_SLEEP;
						REQ_HIB: nxt_state = PMC_HIB;
						default: nxt_state = state_ff;
					endcase
				end
			end
			PMC_SLEEP: begin
				if (sleepWake) begin
					wake = 1'b1;
					nxt_state = PMC_RESUME;
				end
			end
			PMC_HIB: begin
				// pin interrupt or reset pin only
				if (syncB_ff[WK_PIN] | syncB_ff[NUM_WAKE]) begin
					wake = 1'b1;
					nxt_state = PMC_RESUME;
				end
			end
			PMC_RESUME: begin
				if (resumeCnt_ff == resumeLen_ff) begin
					nxt_state = PMC_ACTIVE;
				end
			end
			default: nxt_state = PMC_ACTIVE;
		endcase
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_ff <= PMC_ACTIVE;
		end else if (clkEn) begin
			state_ff <= nxt_state;
		end
	end

	// resume timer length chosen by the mode being left
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			resumeCnt_ff <= '0;
			resumeLen_ff <= '0;
		end else if (clkEn) begin
			if (state_ff != PMC_RESUME) begin
				resumeCnt_ff <= '0;
				resumeLen_ff <= (state_ff == PMC_HIB) ?
					CNT_W'(HIB_RESUME_CYC - 1) :
					CNT_W'(SLEEP_RESUME_CYC - 1);
			end else begin
				resumeCnt_ff <= resumeCnt_ff + 1'b1;
			end
		end
	end

	// cpu override holds until firmware rewrites the active template
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			cpuForce_ff <= 1'b0;
		end else if (clkEn) begin
			if (wake) begin
				cpuForce_ff <= 1'b1;
			end else if (regWr && regAddr == ADDR_ACT_TMPL) begin
				cpuForce_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// regulator buzzing in sleep
	// ----------------------------------------
	logic [CNT_W-1:0] buzzCnt_ff;
	logic             buzzOn;

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			buzzCnt_ff <= '0;
		end else if (clkEn) begin
			if (state_ff != PMC_SLEEP ||
				buzzCnt_ff == CNT_W'(BUZZ_PERIOD_CYC - 1)) begin
				buzzCnt_ff <= '0;
			end else begin
				buzzCnt_ff <= buzzCnt_ff + 1'b1;
			end
		end
	end
	assign buzzOn = (buzzCnt_ff < CNT_W'(BUZZ_ON_CYC));

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic [NUM_SUBSYS-1:0] nxt_enable;
	logic                  wakeSeen_ff;

	always_comb begin
		unique case (state_ff)
			PMC_ACTIVE: nxt_enable = actTmpl_ff;
			PMC_ALT: nxt_enable = altTmpl_ff;
			PMC_SLEEP: nxt_enable = SLEEP_KEEP;
			PMC_HIB: nxt_enable = '0;
			PMC_RESUME: nxt_enable = '0;
			default: nxt_enable = '0;
		endcase
		if (state_ff == PMC_ACTIVE && cpuForce_ff) begin
			nxt_enable[SUBSYS_CPU] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			subsysClkEn <= '1;
			subsysBiasEn <= '1;
			digRegEn <= 1'b1;
			anaRegEn <= 1'b1;
			hibRegEn <= 1'b1;
			fastOscEn <= 1'b1;
			lowSpeedInternalOscEn <= 1'b1;
			watchCrystalOscEn <= 1'b1;
			pinHold <= 1'b0;
			pinIrqCfgHold <= 1'b0;
			globalMode <= 3'h0;
			wakeEvent <= 1'b0;
			wakeSeen_ff <= 1'b0;
			regRdData <= '0;
		end else if (clkEn) begin
			subsysClkEn <= nxt_enable;
			subsysBiasEn <= nxt_enable;
			digRegEn <= (state_ff == PMC_SLEEP) ? buzzOn :
				(state_ff != PMC_HIB);
			anaRegEn <= (state_ff == PMC_SLEEP) ? buzzOn :
				(state_ff != PMC_HIB);
			hibRegEn <= 1'b1;
			fastOscEn <= (state_ff != PMC_SLEEP) &&
				(state_ff != PMC_HIB);
			lowSpeedInternalOscEn <= (state_ff != PMC_HIB);
			watchCrystalOscEn <= (state_ff != PMC_HIB);
			pinHold <= (state_ff == PMC_HIB);
			pinIrqCfgHold <= (state_ff == PMC_HIB);
			globalMode <= state_ff;
			// a held wake level gives one pulse, not one per cycle
			wakeSeen_ff <= wake;
			wakeEvent <= wake && !wakeSeen_ff;
			regRdData <= '0;
			if (regRd) begin
				unique case (regAddr)
					ADDR_ACT_TMPL: regRdData <= actTmpl_ff;
					ADDR_ALT_TMPL: regRdData <= altTmpl_ff;
					ADDR_WAKE_EN: regRdData <= wakeEn_ff;
					ADDR_STATUS: regRdData <= {4'h0, cpuForce_ff, state_ff};
					ADDR_TW_LO: regRdData <= tw.count[7:0];
					ADDR_TW_HI: regRdData <= {3'h0, tw.count[TW_W-1:8]};
					default: regRdData <= '0;
				endcase
			end
		end
	end

endmodule

/* File: pmc_pkg.sv */
// shared constants and types for the power mode controller
package pmc_pkg;

	// ----------------------------------------
	// subsystem and register map
	// ----------------------------------------
	localparam int NUM_SUBSYS = 8;
	localparam int SUBSYS_CPU = 0;
	localparam int SUBSYS_FLASH = 1;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] ADDR_ACT_TMPL = 4'h0;
	localparam logic [3:0] ADDR_ALT_TMPL = 4'h1;
	localparam logic [3:0] ADDR_MODE_REQ = 4'h2;
	localparam logic [3:0] ADDR_WAKE_EN = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_TW_LO = 4'h5;
	localparam logic [3:0] ADDR_TW_HI = 4'h6;
	localparam logic [3:0] ADDR_TW_CTRL = 4'h7;
	localparam logic [7:0] ACT_TMPL_RST = 8'hff;
	localparam logic [7:0] ALT_TMPL_RST = 8'hfc;
	localparam logic [7:0] WAKE_EN_RST = 8'h00;
	localparam logic [7:0] SLEEP_KEEP = 8'h00;

	// ----------------------------------------
	// wakeup enable bit positions
	// ----------------------------------------
	localparam int WK_PERIPH = 0;
	localparam int WK_SUPV = 1;
	localparam int WK_TWHEEL = 2;
	localparam int WK_PIN = 3;
	localparam int WK_COMP = 4;
	localparam int WK_I2C = 5;
	localparam int WK_RTC = 6;
	localparam int WK_LVD = 7;
	localparam int NUM_WAKE = 8;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int SLEEP_RESUME_NS = 15000;
	localparam int HIB_RESUME_NS = 100000;
	localparam int SLEEP_RESUME_CYC = SLEEP_RESUME_NS * CLK_MHZ / 1000 - 1;
	localparam int HIB_RESUME_CYC = HIB_RESUME_NS * CLK_MHZ / 1000 - 1;
	localparam int BUZZ_PERIOD_CYC = 4000;
	localparam int BUZZ_ON_CYC = 40;
	localparam int TW_W = 13;
	localparam int TW_TICK_HZ = 1000;
	localparam int TW_DIV_CYC = CLK_MHZ * 1000000 / TW_TICK_HZ;
	localparam int CNT_W = 16;

	// ----------------------------------------
	// modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		PMC_ACTIVE = 3'b000,
		PMC_ALT = 3'b001,
		PMC_SLEEP = 3'b010,
		PMC_HIB = 3'b011,
		PMC_RESUME = 3'b100
	} pmc_state_t;

	localparam logic [1:0] REQ_ALT = 2'h1;
	localparam logic [1:0] REQ_SLEEP = 2'h2;
	localparam logic [1:0] REQ_HIB = 2'h3;

endpackage

/* File: pmc_tw_if.sv */
// link between controller and timewheel counter
`timescale 1ns/1ps
interface pmc_tw_if;
	import pmc_pkg::*;
	logic            run;
	logic            clear;
	logic [TW_W-1:0] count;
	logic            wrap;
	modport ctrl (output run, output clear, input count, input wrap);
	modport wheel (input run, input clear, output count, output wrap);
endinterface

/* File: pmc_timewheel.sv */
// 13-bit periodic timewheel at 1 kHz, halted while in hibernate
`timescale 1ns/1ps
module pmc_timewheel
	import pmc_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rstSyncN,
	input  wire logic clkEn,
	// controller side
	pmc_tw_if.wheel   tw
);

	logic [CNT_W-1:0] divCnt_ff;
	logic [TW_W-1:0]  wheel_ff;
	logic             wrap_ff;
	logic             tick;

	assign tick = (divCnt_ff == CNT_W'(TW_DIV_CYC - 1));
	assign tw.count = wheel_ff;
	assign tw.wrap = wrap_ff;

	// ----------------------------------------
	// divider to 1 kHz and counter
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			divCnt_ff <= '0;
			wheel_ff <= '0;
			wrap_ff <= 1'b0;
		end else if (clkEn) begin
			wrap_ff <= 1'b0;
			if (tw.clear) begin
				divCnt_ff <= '0;
				wheel_ff <= '0;
			end else if (tw.run) begin
				divCnt_ff <= tick ? '0 : divCnt_ff + 1'b1;
				if (tick) begin
					wheel_ff <= wheel_ff + 1'b1;
					wrap_ff <= &wheel_ff;
				end
			end
		end
	end

endmodule

/* File: pmc_properties.sv */
// port assertions for the power mode controller
`timescale 1ns/1ps
module pmc_properties
	import pmc_pkg::*;
(
	input wire logic       clk, rst_n, regWr,
	input wire logic       pinInterruptUnitIrq, externalResetPinN,
	input wire logic [7:0] subsysClkEn, subsysBiasEn,
	input wire logic       digRegEn, anaRegEn, hibRegEn, fastOscEn,
	input wire logic       lowSpeedInternalOscEn, watchCrystalOscEn,
	input wire logic       pinHold, pinIrqCfgHold, wakeEvent,
	input wire logic [2:0] globalMode
);
	logic [15:0] resCnt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// cycles spent in resume, bounds the wake latency
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			resCnt <= 16'h0;
		else if (globalMode == 3'h4)
			resCnt <= resCnt + 16'h1;
		else
			resCnt <= 16'h0;
	end

	a_bias_follows: assert property (subsysBiasEn == subsysClkEn)
		else $error("bias enable differs from clock enable");
	a_sleep_off: assert property (globalMode == 3'h2 |->
		subsysClkEn == 8'h0)
		else $error("subsystem running in sleep");
	a_sleep_osc: assert property (globalMode == 3'h2 |-> !fastOscEn &&
		lowSpeedInternalOscEn && watchCrystalOscEn)
		else $error("wrong oscillators in sleep");
	a_hib_regs: assert property (globalMode == 3'h3 |-> !digRegEn &&
		!anaRegEn && hibRegEn && !lowSpeedInternalOscEn && subsysClkEn == 8'h0)
		else $error("hibernate supplies wrong");
	a_hib_hold: assert property (globalMode == 3'h3 |->
		pinHold && pinIrqCfgHold)
		else $error("pins not held in hibernate");
	a_hib_exit_pin: assert property ((globalMode == 3'h3 &&
		!pinInterruptUnitIrq && externalResetPinN)[*6] |=> globalMode == 3'h3)
		else $error("hibernate left without pin event");
	a_resume_bound: assert property (resCnt < 16'd4000)
		else $error("resume too long");
	a_wake_cpu_on: assert property (globalMode == 3'h4 ##1
		globalMode == 3'h0 |-> ##[0:2] subsysClkEn[SUBSYS_CPU])
		else $error("cpu not forced on after wake");
	a_wake_pulse: assert property (wakeEvent |=> !wakeEvent)
		else $error("wake pulse too long");
	a_entry_by_req: assert property (globalMode == 3'h0 ##1
		globalMode inside {3'h1, 3'h2, 3'h3} |->
		$past(regWr, 3) || $past(regWr, 4) || $past(regWr, 5))
		else $error("low power mode entered without request");

	c_alt: cover property (globalMode == 3'h1 ##1 globalMode == 3'h0);
	c_sleep_wake: cover property (globalMode == 3'h2 ##1 globalMode == 3'h4);
	c_hib_wake: cover property (globalMode == 3'h3 ##1 globalMode == 3'h4);
endmodule

/* File: pmc_wake_model.sv */
// wake and reset event sources around the controller
`timescale 1ns/1ps
module pmc_wake_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       go,
	input  wire logic [3:0] sel,
	output logic      [9:0] lines
);
	logic [3:0] cur;
	logic [2:0] cnt;

	// each event is a level held four cycles, long enough for the syncs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= 4'h0;
			cnt <= 3'h0;
		end else if (go) begin
			cur <= sel;
			cnt <= 3'h4;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
		end
	end
	// bit 7 is the reset pin, inverted at the top
	assign lines = (cnt != 3'h0) ? (10'h1 << cur) : 10'h0;
endmodule

/* File: tb_power_mode_controller.sv */
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb_power_mode_controller
	import pmc_pkg::*;
;
	logic       clk = 0, rst_n = 0, regWr = 0, regRd = 0, go = 0;
	logic       clkEn = 1;
	logic [3:0] regAddr = 4'h0, sel = 4'h0;
	logic [7:0] regWrData = 8'h0, regRdData, subsysClkEn, subsysBiasEn, rd;
	logic [9:0] wk;
	logic       digRegEn, anaRegEn, hibRegEn, fastOscEn, lsOsc, wcOsc;
	logic       pinHold, pinIrqCfgHold, wakeEvent;
	logic [2:0] globalMode;
	int         failures = 0, check_count = 0, cyc = 0, n;

	initial forever #12.5 clk = ~clk;

	pmc_wake_model i_src (.clk(clk), .rst_n(rst_n), .go(go), .sel(sel),
		.lines(wk));

	pmc_power_mode_controller i_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .periphIrq(wk[0]),
		.supervisorIrq(wk[1]), .pinInterruptUnitIrq(wk[2]),
		.comparatorIrq(wk[3]), .i2cIrq(wk[4]), .rtcIrq(wk[5]),
		.lowVoltageDetectIrq(wk[6]), .externalResetPinN(~wk[7]),
		.watchdogResetEvent(wk[8]), .preciseSupplyReset(wk[9]),
		.subsysClkEn(subsysClkEn), .subsysBiasEn(subsysBiasEn),
		.digRegEn(digRegEn), .anaRegEn(anaRegEn), .hibRegEn(hibRegEn),
		.fastOscEn(fastOscEn), .lowSpeedInternalOscEn(lsOsc),
		.watchCrystalOscEn(wcOsc), .pinHold(pinHold),
		.pinIrqCfgHold(pinIrqCfgHold), .globalMode(globalMode),
		.wakeEvent(wakeEvent));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 0;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		regRd <= 1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 0;
		#1 rd = regRdData;
		chk(rd, exp);
	endtask

	task automatic fire(input logic [3:0] s);
		@(posedge clk);
		go <= 1;
		sel <= s;
		@(posedge clk);
		go <= 0;
	endtask

	// bounded wait for a mode, returns the cycles taken
	task automatic waitm(input logic [2:0] m, input int lim, output int k);
		k = 0;
		while (globalMode !== m && k < lim) begin
			@(posedge clk);
			#1 k++;
		end
		chk(globalMode, m);
	endtask

	task automatic print_verdict;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// the full run needs about 4750 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			print_verdict;
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		repeat (4) @(posedge clk);
		rdchk(4'h0, 8'hff);
		rdchk(4'h1, 8'hfc);
		rdchk(4'h3, 8'h00);
		rdchk(4'hf, 8'h00);
		chk(globalMode, 3'h0);
		wr(4'h0, 8'ha4);
		repeat (4) @(posedge clk);
		chk(subsysClkEn, 8'ha4);
		chk(subsysBiasEn, 8'ha4);
		// a write while the clock enable is low must be lost
		@(posedge clk);
		clkEn <= 0;
		wr(4'h0, 8'h11);
		clkEn <= 1;
		rdchk(4'h0, 8'ha4);
		wr(4'h3, 8'h61);
		wr(4'h1, 8'h3c);
		wr(4'h2, 8'h1);
		waitm(3'h1, 10, n);
		repeat (2) @(posedge clk);
		chk(subsysClkEn, 8'h3c);
		fire(4'h0);
		waitm(3'h0, 10, n);
		repeat (8) @(posedge clk);
		chk(subsysClkEn, 8'ha5);
		rdchk(4'h4, 8'h08);
		wr(4'h2, 8'h2);
		waitm(3'h2, 10, n);
		chk({fastOscEn, lsOsc, wcOsc}, 3'h3);
		chk(subsysClkEn, 8'h00);
		fire(4'h5);
		waitm(3'h4, 10, n);
		waitm(3'h0, 700, n);
		chk(n < 600, 1);
		repeat (8) @(posedge clk);
		wr(4'h3, 8'h00);
		wr(4'h2, 8'h1);
		waitm(3'h1, 10, n);
		fire(4'h8);
		waitm(3'h0, 10, n);
		repeat (8) @(posedge clk);
		wr(4'h2, 8'h3);
		waitm(3'h3, 10, n);
		chk({pinHold, pinIrqCfgHold}, 2'h3);
		chk({digRegEn, anaRegEn, hibRegEn}, 3'h1);
		fire(4'h5);
		repeat (20) @(posedge clk);
		chk(globalMode, 3'h3);
		fire(4'h2);
		waitm(3'h4, 10, n);
		waitm(3'h0, 4100, n);
		chk(n < 4000, 1);
		print_verdict;
	end
endmodule

bind pmc_power_mode_controller pmc_properties i_chk (.clk(clk), .rst_n(rst_n),
	.regWr(regWr), .pinInterruptUnitIrq(pinInterruptUnitIrq),
	.externalResetPinN(externalResetPinN), .subsysClkEn(subsysClkEn),
	.subsysBiasEn(subsysBiasEn), .digRegEn(digRegEn), .anaRegEn(anaRegEn),
	.hibRegEn(hibRegEn), .fastOscEn(fastOscEn),
	.lowSpeedInternalOscEn(lowSpeedInternalOscEn),
	.watchCrystalOscEn(watchCrystalOscEn), .pinHold(pinHold),
	.pinIrqCfgHold(pinIrqCfgHold), .wakeEvent(wakeEvent),
	.globalMode(globalMode));
